// ---- design/i2cr_cfg.svh ----
`ifndef I2CR_CFG_SVH
`define I2CR_CFG_SVH

// ****************************************************************
// Bus address and register map
// ****************************************************************
`define I2CR_DEV_ID        5'h04
`define I2CR_LAST_REG      6'h07
`define I2CR_FIRST_RO      6'h06
`define I2CR_A_PWR         3'h0
`define I2CR_A_PM2         3'h1
`define I2CR_A_CTL1        3'h2
`define I2CR_A_CTL2        3'h3
`define I2CR_A_CTL3        3'h4
`define I2CR_A_BS          3'h5
`define I2CR_A_TST1        3'h6
`define I2CR_A_TST2        3'h7

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define I2CR_RST_PWR       8'hFF
`define I2CR_RST_PM2       8'h01
`define I2CR_RST_CTL1      8'h01
`define I2CR_RST_CTL2      8'h00
`define I2CR_RST_CTL3      8'h00
`define I2CR_RST_BS        8'h00
`define I2CR_RST_TST       8'h00
`define I2CR_MSK_PWR       8'hFF
`define I2CR_MSK_PM2       8'h07
`define I2CR_MSK_CTL1      8'h7F
`define I2CR_MSK_CTL2      8'h60
`define I2CR_MSK_CTL3      8'h83
`define I2CR_MSK_BS        8'h2F

// ****************************************************************
// Field positions
// ****************************************************************
`define I2CR_B_TIMING_RESET_N        0
`define I2CR_B_SUM         1
`define I2CR_B_HIGHPASS_ENABLE        0
`define I2CR_B_DIF         1
`define I2CR_B_CKS         3
`define I2CR_B_TDM         5
`define I2CR_B_SLOW        0
`define I2CR_B_SD          1
`define I2CR_B_DP          7
`define I2CR_B_DSEL        0
`define I2CR_B_BITSTREAM_CLOCK_POLARITY        2
`define I2CR_B_PHASE_MODULATION_ENABLE        3
`define I2CR_B_BITSTREAM_CLOCK_RATIO        5

// ****************************************************************
// Timing
// ****************************************************************
`define I2CR_CLK_PERIOD_NS 10
`define I2CR_SCL_PERIOD_NS 2500

`endif

// ---- design/i2cr_pkg.sv ----
package i2cr_pkg;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_REG       = 9'h008,
      ST_REG_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RACK      = 9'h100
   } i2cr_state_t;

endpackage

// ---- design/i2cr_sync.sv ----
module i2cr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             srst,
   // Data.
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("i2cr_sync: WIDTH must be at least 1");
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

// ---- design/i2cr_ctrl_port.sv ----
`include "i2cr_cfg.svh"

module i2cr_ctrl_port
   import i2cr_pkg::*;
(
   // System clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Converter clock.
   input  wire logic       mclk,
   // Bus pins; SDA is open drain.
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Straps and power-down pin.
   input  wire logic [1:0] strap_address_bits,
   input  wire logic       powerdown_n_pin,
   // Converter fields, in the mclk domain.
   output logic [7:0]      channel_power_on,
   output logic [1:0]      summation_select,
   output logic            timing_reset_n,
   output logic            highpass_enable,
   output logic [1:0]      word_format_select,
   output logic [3:0]      speed_clock_select,
   output logic [1:0]      multiplex_select,
   output logic            slow_rolloff_select,
   output logic            short_latency_select,
   output logic            bitstream_output_select,
   output logic [1:0]      bitstream_rate_select,
   output logic            bitstream_clock_polarity,
   output logic            phase_modulation_enable,
   output logic            bitstream_clock_ratio
);

   // ****************************************************************
   // Timing check
   // ****************************************************************
   localparam int SCL_PERIOD_CYC = `I2CR_SCL_PERIOD_NS / `I2CR_CLK_PERIOD_NS;
   localparam int SYNC_LAT_CYC   = 4;

   // Oversampling needs each SCL phase to outlast the pin synchroniser.
   if (SCL_PERIOD_CYC / 2 <= SYNC_LAT_CYC) begin : g_chk
      $error("i2cr_ctrl_port: system clock too slow for a 400 kHz bus");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [4:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       pdn_n_s;
   logic [1:0] strap_s;
   logic       scl_p_q;
   logic       sda_p_q;
   logic       start_det;
   logic       stop_det;
   logic       scl_rise;
   logic       scl_fall;

   i2cr_sync #(
      .WIDTH (5)
   ) u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .din  ({scl_i, sda_i, powerdown_n_pin, strap_address_bits}),
      .dout (pins_s)
   );

   assign scl_s   = pins_s[4];
   assign sda_s   = pins_s[3];
   assign pdn_n_s = pins_s[2];
   assign strap_s = pins_s[1:0];

   always_ff @(posedge clk) begin
      if (srst) begin
         scl_p_q <= 1'b0;
         sda_p_q <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;

   // ****************************************************************
   // Bus protocol engine
   // ****************************************************************
   i2cr_state_t state_q;
   i2cr_state_t state_d;
   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   logic [7:0]  shift_q;
   logic [7:0]  shift_d;
   logic        got_q;
   logic        got_d;
   logic        rw_q;
   logic        rw_d;
   logic [5:0]  ptr_q;
   logic [5:0]  ptr_d;
   logic        oe_q;
   logic        oe_d;
   logic        wr_en;
   logic        addr_match;
   logic [5:0]  ptr_next;
   logic [7:0]  rd_byte;
   logic [7:0]  regs_q [0:7];
   logic [7:0]  regs_d [0:7];

   assign addr_match = (shift_q[7:3] == `I2CR_DEV_ID)
                     && (shift_q[2:1] == strap_s);
   assign ptr_next   = (ptr_q >= `I2CR_LAST_REG) ? 6'h00 : ptr_q + 6'h01;
   assign rd_byte    = (ptr_q <= `I2CR_LAST_REG) ? regs_q[ptr_q[2:0]] : 8'h00;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      got_d   = got_q;
      rw_d    = rw_q;
      ptr_d   = ptr_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      if (stop_det) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (start_det) begin
         state_d = ST_ADDR;
         cnt_d   = 3'h0;
         got_d   = 1'b0;
         oe_d    = 1'b0;
      end else if (scl_rise) begin
         case (state_q)
            ST_ADDR, ST_REG, ST_WDATA: begin
               shift_d = {shift_q[6:0], sda_s};
               cnt_d   = cnt_q + 3'h1;
               got_d   = (cnt_q == 3'h7);
            end
            ST_RDATA: begin
               cnt_d = cnt_q + 3'h1;
               got_d = (cnt_q == 3'h7);
            end
            ST_RACK: begin
               if (sda_s) begin
                  state_d = ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (got_q) begin
                  got_d = 1'b0;
                  if (addr_match) begin
                     oe_d    = 1'b1;
                     rw_d    = shift_q[0];
                     state_d = ST_ADDR_ACK;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_REG: begin
               if (got_q) begin
                  got_d   = 1'b0;
                  ptr_d   = shift_q[5:0];
                  oe_d    = 1'b1;
                  state_d = ST_REG_ACK;
               end
            end
            ST_WDATA: begin
               if (got_q) begin
                  got_d   = 1'b0;
                  wr_en   = 1'b1;
                  ptr_d   = ptr_next;
                  oe_d    = 1'b1;
                  state_d = ST_WDATA_ACK;
               end
            end
            ST_ADDR_ACK, ST_RACK: begin
               if (rw_q) begin
                  shift_d = rd_byte;
                  oe_d    = ~rd_byte[7];
                  ptr_d   = ptr_next;
                  cnt_d   = 3'h0;
                  state_d = ST_RDATA;
               end else begin
                  oe_d    = 1'b0;
                  state_d = ST_REG;
               end
            end
            ST_REG_ACK, ST_WDATA_ACK: begin
               oe_d    = 1'b0;
               state_d = ST_WDATA;
            end
            ST_RDATA: begin
               if (got_q) begin
                  got_d   = 1'b0;
                  oe_d    = 1'b0;
                  state_d = ST_RACK;
               end else begin
                  shift_d = {shift_q[6:0], 1'b0};
                  oe_d    = ~shift_q[6];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Drive is turned on only after a sampled SCL fall; a start or stop can only release it.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         cnt_q   <= 3'h0;
         shift_q <= 8'h00;
         got_q   <= 1'b0;
         rw_q    <= 1'b0;
         ptr_q   <= 6'h00;
         oe_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         got_q   <= got_d;
         rw_q    <= rw_d;
         ptr_q   <= ptr_d;
         oe_q    <= oe_d;
      end
   end

   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;

   // ****************************************************************
   // Register bank
   // ****************************************************************
   function automatic logic [7:0] reg_rst(input logic [2:0] idx);
      case (idx)
         `I2CR_A_PWR:  reg_rst = `I2CR_RST_PWR;
         `I2CR_A_PM2:  reg_rst = `I2CR_RST_PM2;
         `I2CR_A_CTL1: reg_rst = `I2CR_RST_CTL1;
         `I2CR_A_CTL2: reg_rst = `I2CR_RST_CTL2;
         `I2CR_A_CTL3: reg_rst = `I2CR_RST_CTL3;
         `I2CR_A_BS:   reg_rst = `I2CR_RST_BS;
         default:      reg_rst = `I2CR_RST_TST;
      endcase
   endfunction

   function automatic logic [7:0] reg_msk(input logic [2:0] idx);
      case (idx)
         `I2CR_A_PWR:  reg_msk = `I2CR_MSK_PWR;
         `I2CR_A_PM2:  reg_msk = `I2CR_MSK_PM2;
         `I2CR_A_CTL1: reg_msk = `I2CR_MSK_CTL1;
         `I2CR_A_CTL2: reg_msk = `I2CR_MSK_CTL2;
         `I2CR_A_CTL3: reg_msk = `I2CR_MSK_CTL3;
         default:      reg_msk = `I2CR_MSK_BS;
      endcase
   endfunction

   // Test registers never take writes, so a stray write cannot upset the converter.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pdn_n_s) begin
            regs_d[i] = reg_rst(3'(i));
         end else if (wr_en && ptr_q < `I2CR_FIRST_RO && ptr_q[2:0] == 3'(i)) begin
            regs_d[i] = shift_q & reg_msk(3'(i));
         end else begin
            regs_d[i] = regs_q[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (srst) begin
            regs_q[i] <= reg_rst(3'(i));
         end else begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   // ****************************************************************
   // Crossing to the converter clock
   // ****************************************************************
   logic [47:0] snap_q;
   logic [47:0] snap_d;
   logic        req_q;
   logic        req_d;
   logic        dirty_q;
   logic        dirty_d;
   logic        launch;
   logic        ack_s;
   logic        req_m;
   logic        seen_q;
   logic        seen_d;
   logic        mrst;
   logic [47:0] cfg_q;
   logic [47:0] cfg_d;

   // A new snapshot waits until the previous one is acknowledged; a write in the
   // launching cycle keeps the dirty flag, so no update is lost.
   assign launch = dirty_q & (req_q == ack_s);

   always_comb begin
      snap_d  = launch ? {regs_q[5], regs_q[4], regs_q[3], regs_q[2], regs_q[1], regs_q[0]} : snap_q;
      req_d   = req_q ^ launch;
      dirty_d = (dirty_q & ~launch) | wr_en | ~pdn_n_s;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         snap_q  <= {`I2CR_RST_BS, `I2CR_RST_CTL3, `I2CR_RST_CTL2, `I2CR_RST_CTL1, `I2CR_RST_PM2, `I2CR_RST_PWR};
         req_q   <= 1'b0;
         dirty_q <= 1'b1;
      end else begin
         snap_q  <= snap_d;
         req_q   <= req_d;
         dirty_q <= dirty_d;
      end
   end

   i2cr_sync #(
      .WIDTH (1)
   ) u_ack_sync (
      .clk  (clk),
      .srst (srst),
      .din  (seen_q),
      .dout (ack_s)
   );

   i2cr_sync #(
      .WIDTH (1)
   ) u_rst_sync (
      .clk  (mclk),
      .srst (1'b0),
      .din  (srst),
      .dout (mrst)
   );

   i2cr_sync #(
      .WIDTH (1)
   ) u_req_sync (
      .clk  (mclk),
      .srst (mrst),
      .din  (req_q),
      .dout (req_m)
   );

   // The snapshot is stable while a request is open, so it is read directly here.
   always_comb begin
      cfg_d  = (req_m != seen_q) ? snap_q : cfg_q;
      seen_d = req_m;
   end

   always_ff @(posedge mclk) begin
      if (mrst) begin
         cfg_q  <= {`I2CR_RST_BS, `I2CR_RST_CTL3, `I2CR_RST_CTL2, `I2CR_RST_CTL1, `I2CR_RST_PM2, `I2CR_RST_PWR};
         seen_q <= 1'b0;
      end else begin
         cfg_q  <= cfg_d;
         seen_q <= seen_d;
      end
   end

   assign channel_power_on         = cfg_q[7:0];
   assign timing_reset_n           = cfg_q[8 + `I2CR_B_TIMING_RESET_N];
   assign summation_select         = cfg_q[8 + `I2CR_B_SUM +: 2];
   assign highpass_enable          = cfg_q[16 + `I2CR_B_HIGHPASS_ENABLE];
   assign word_format_select       = cfg_q[16 + `I2CR_B_DIF +: 2];
   assign speed_clock_select       = cfg_q[16 + `I2CR_B_CKS +: 4];
   assign multiplex_select         = cfg_q[24 + `I2CR_B_TDM +: 2];
   assign slow_rolloff_select      = cfg_q[32 + `I2CR_B_SLOW];
   assign short_latency_select     = cfg_q[32 + `I2CR_B_SD];
   assign bitstream_output_select  = cfg_q[32 + `I2CR_B_DP];
   assign bitstream_rate_select    = cfg_q[40 + `I2CR_B_DSEL +: 2];
   assign bitstream_clock_polarity = cfg_q[40 + `I2CR_B_BITSTREAM_CLOCK_POLARITY];
   assign phase_modulation_enable  = cfg_q[40 + `I2CR_B_PHASE_MODULATION_ENABLE];
   assign bitstream_clock_ratio    = cfg_q[40 + `I2CR_B_BITSTREAM_CLOCK_RATIO];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_addr_byte_done;
      state_q == ST_ADDR ##0 got_q ##0 scl_fall & ~start_det & ~stop_det;
   endsequence

   sequence s_read_nack;
      state_q == ST_RACK ##0 scl_rise ##0 sda_s & ~stop_det & ~start_det;
   endsequence

   AST_ADDR_ACK: assert property (s_addr_byte_done ##0 addr_match |=> sda_oe && state_q == ST_ADDR_ACK)
      else $error("own address was not acknowledged");

   AST_ADDR_IGNORE: assert property (s_addr_byte_done ##0 !addr_match |=> !sda_oe && state_q == ST_IDLE)
      else $error("foreign address was acknowledged");

   AST_DIRECTION: assert property (state_q == ST_ADDR_ACK && scl_fall && !start_det && !stop_det
                                   |=> (state_q == ST_RDATA) == $past(rw_q))
      else $error("direction bit did not pick the transfer");

   AST_WRITE_INC: assert property (wr_en |=> ptr_q == (($past(ptr_q) >= 6'h07) ? 6'h00 : $past(ptr_q) + 6'h01))
      else $error("address counter did not advance after a write");

   AST_WRITE_STORE: assert property (wr_en && ptr_q == 6'h00 && pdn_n_s |=> regs_q[0] == $past(shift_q))
      else $error("written byte not stored");

   AST_NACK_END: assert property (s_read_nack |=> state_q == ST_IDLE ##1 !sda_oe [*3])
      else $error("device kept sending after a missing acknowledge");

   AST_START: assert property (start_det && !stop_det |=> state_q == ST_ADDR && !sda_oe)
      else $error("start did not restart the receiver");

   AST_STOP: assert property (stop_det |=> state_q == ST_IDLE && !sda_oe)
      else $error("stop did not return to idle");

   AST_SDA_LOW_SCL: assert property ($changed(sda_oe) |-> $past(scl_fall || start_det || stop_det))
      else $error("SDA drive changed outside the SCL low phase");

   AST_PDN_DEFAULT: assert property (!pdn_n_s |=> regs_q[0] == 8'hFF && regs_q[1] == 8'h01 && regs_q[3] == 8'h00)
      else $error("power-down did not restore defaults");

   AST_CDC_DELIVER: assert property (launch |-> ##[1:40] ack_s == req_q)
      else $error("configuration crossing did not complete");

endmodule

// ---- tb/i2cr_mst.sv ----
module i2cr_mst (
   // Pacing clock.
   input  wire logic clk,
   // Bus lines; sda_m high means released.
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda_m
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Eight clk a quarter runs the bus faster than fast mode to keep the run short.
   // The receiver only needs each SCL phase to outlast its pin synchroniser.
   task automatic qtr();
      repeat (8) @(posedge clk);
      #1;
   endtask
   // Serves from idle and as a repeated start.
   task automatic start();
      sda_m = 1'b1;
      qtr();
      scl = 1'b1;
      qtr();
      sda_m = 1'b0;
      qtr();
      scl = 1'b0;
      qtr();
   endtask
   task automatic stop();
      sda_m = 1'b0;
      qtr();
      scl = 1'b1;
      qtr();
      sda_m = 1'b1;
      qtr();
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_m = b;
      qtr();
      scl = 1'b1;
      qtr();
      r = sda_w;
      qtr();
      scl = 1'b0;
      qtr();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(last, r);
   endtask
endmodule

// ---- tb/i2cr_ctrl_port_tb.sv ----
module i2cr_ctrl_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } i2cr_row_t;
   logic       clk, mclk, srst, scl, sda_m, sda_o, sda_oe, pd_n;
   logic       trst_n, hpf, slow, sdl, bso, bcp, pme, bcr;
   logic [1:0] strap, sum, wfmt, mux, brs;
   logic [3:0] spd;
   logic [7:0] pwr, d;
   logic       a;
   wire logic  sda_w;
   int         failures = 0;
   int         total_checks = 0;
   logic [7:0] dflt [8] = '{8'hFF, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] bad [2] = '{8'h22, 8'h64};
   i2cr_row_t  rows [14] = '{
      '{8'h00, 8'h5A, 8'h5A}, '{8'h00, 8'hA5, 8'hA5}, '{8'h01, 8'h07, 8'h07}, '{8'h01, 8'h02, 8'h02},
      '{8'h01, 8'h04, 8'h04}, '{8'h01, 8'h00, 8'h00}, '{8'h02, 8'h7F, 8'h7F}, '{8'h02, 8'h00, 8'h00},
      '{8'h03, 8'h60, 8'h60}, '{8'h03, 8'h20, 8'h20}, '{8'h04, 8'h83, 8'h83}, '{8'h05, 8'h2F, 8'h2F},
      '{8'h00, 8'hFF, 8'hFF}, '{8'h04, 8'h00, 8'h00}};
   // ****************
   // Clocks and wiring
   // ****************
   initial clk = 1'b0;
   initial mclk = 1'b0;
   always #5 clk = ~clk;
   always #32 mclk = ~mclk;
   // SDA has a pull-up; either party may pull it low.
   assign sda_w = (sda_oe ? sda_o : 1'b1) & sda_m;
   i2cr_mst mst_u (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
   i2cr_ctrl_port dut_u (.clk(clk), .srst(srst), .mclk(mclk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .strap_address_bits(strap), .powerdown_n_pin(pd_n), .channel_power_on(pwr),
      .summation_select(sum), .timing_reset_n(trst_n), .highpass_enable(hpf), .word_format_select(wfmt),
      .speed_clock_select(spd), .multiplex_select(mux), .slow_rolloff_select(slow),
      .short_latency_select(sdl), .bitstream_output_select(bso), .bitstream_rate_select(brs),
      .bitstream_clock_polarity(bcp), .phase_modulation_enable(pme), .bitstream_clock_ratio(bcr));
   // ****************
   // Tasks
   // ****************
   function automatic logic [7:0] view(input logic [7:0] ra);
      case (ra)
         8'h00: return pwr;
         8'h01: return {5'h00, sum, trst_n};
         8'h02: return {1'b0, spd, wfmt, hpf};
         8'h03: return {1'b0, mux, 5'h00};
         8'h04: return {bso, 5'h00, sdl, slow};
         8'h05: return {2'h0, bcr, 1'b0, pme, bcp, brs};
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic adr(input logic rw, input logic [7:0] ra);
      mst_u.start();
      mst_u.wbyte({5'h04, strap, rw}, a);
      chk({7'h00, a}, 8'h01);
      if (!rw) begin
         mst_u.wbyte(ra, a);
         chk({7'h00, a}, 8'h01);
      end
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] dv);
      adr(1'b0, ra);
      mst_u.wbyte(dv, a);
      chk({7'h00, a}, 8'h01);
      mst_u.stop();
   endtask
   task automatic rd(input logic rnd, input logic [7:0] ra, input logic [7:0] e);
      if (rnd) adr(1'b0, ra);
      adr(1'b1, 8'h00);
      mst_u.rbyte(1'b1, d);
      mst_u.stop();
      chk(d, e);
      chk({7'h00, sda_oe}, 8'h00);
   endtask
   task automatic rst_pulse(input int n);
      srst = 1'b1;
      repeat (n) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (60) @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      pd_n = 1'b1;
      strap = 2'h2;
      rst_pulse(12);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(1'b1, rows[i].a, rows[i].e);
         repeat (60) @(posedge clk);
         chk(view(rows[i].a), rows[i].e);
      end
      rst_pulse(30);
      for (int i = 0; i < 8; i++) chk(view(i[7:0]), dflt[i]);
      adr(1'b0, 8'h00);
      adr(1'b1, 8'h00);
      for (int i = 0; i < 9; i++) begin
         mst_u.rbyte(i == 8, d);
         chk(d, dflt[i % 8]);
      end
      mst_u.stop();
      rd(1'b0, 8'h00, 8'h01);
      adr(1'b0, 8'h05);
      foreach (bad[i]) begin
         mst_u.wbyte(8'h21 * (i + 1), a);
         chk({7'h00, a}, 8'h01);
      end
      mst_u.wbyte(8'h00, a);
      mst_u.wbyte(8'hC3, a);
      mst_u.stop();
      rd(1'b0, 8'h00, 8'h01);
      rd(1'b1, 8'h05, 8'h21);
      rd(1'b1, 8'h00, 8'hC3);
      foreach (bad[i]) begin
         mst_u.start();
         mst_u.wbyte(bad[i], a);
         chk({7'h00, a}, 8'h00);
         mst_u.wbyte(8'h00, a);
         mst_u.wbyte(8'h00, a);
         mst_u.stop();
      end
      strap = 2'h1;
      repeat (10) @(posedge clk);
      #1;
      rd(1'b1, 8'h00, 8'hC3);
      pd_n = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      pd_n = 1'b1;
      repeat (60) @(posedge clk);
      chk(view(8'h00), 8'hFF);
      rd(1'b1, 8'h00, 8'hFF);
      end_sim();
   end
   initial begin
      #900us;
      failures++;
      end_sim();
   end
endmodule
